// >>> pkg/autobaud_pkg.sv
// Constants, state encoding and prescaler decode for the auto-baud measurement block.
// Assumes the block clock is the oscillator that feeds the baud prescaler.
package autobaud_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int          DIV_W       = 16;
    localparam int          PRE_W       = 9;
    localparam logic [15:0] DIV_RESET   = 16'h0000;
    localparam logic [15:0] DIV_MAX     = 16'hffff;
    localparam logic [15:0] DIV_ONE     = 16'h0001;

    // ----------------------------------------------------------------
    // Counter clock during measurement: oscillator over 512, 128, 128 or 32
    // ----------------------------------------------------------------
    localparam logic [8:0]  PRE_LAST_SLOW = 9'h1ff;
    localparam logic [8:0]  PRE_LAST_MID  = 9'h07f;
    localparam logic [8:0]  PRE_LAST_FAST = 9'h01f;
    localparam logic [8:0]  PRE_ONE       = 9'h001;

    // ----------------------------------------------------------------
    // Edge counting
    // ----------------------------------------------------------------
    localparam logic [2:0]  FIRST_RISE  = 3'h1;
    localparam logic [2:0]  LAST_RISE   = 3'h5;
    localparam logic [2:0]  RISE_ONE    = 3'h1;

    typedef enum logic [4:0] {
        ST_IDLE       = 5'h01,
        ST_WAIT_BREAK = 5'h02,
        ST_WAIT_START = 5'h04,
        ST_WAIT_RISE  = 5'h08,
        ST_COUNT      = 5'h10
    } abd_state_t;

    // Last prescaler count before a counter tick, from the two rate selects.
    function automatic logic [8:0] prescale_last(input logic wide, input logic fast);
        case ({wide, fast})
            2'b00:   prescale_last = PRE_LAST_SLOW;
            2'b11:   prescale_last = PRE_LAST_FAST;
            default: prescale_last = PRE_LAST_MID;
        endcase
    endfunction : prescale_last

endpackage : autobaud_pkg

// >>> pkg/rx_edge_if.sv
// Carrier for the receive-line level and its edge pulses between the detector and the controller.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface rx_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport det (output level, output rise, output fall);
    modport user (input level, input rise, input fall);
endinterface : rx_edge_if

// >>> rtl/rx_edge_detect.sv
// Edge detector for the receive line; one-cycle pulses on each rising and falling edge.
// Assumes the receive line is already synchronous to the block clock.
`timescale 1ns/1ns
module rx_edge_detect (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic rx_in,
    rx_edge_if.det    ev
);
    logic rx_prev_ff;

    // A mark level is assumed at reset so no false edge follows release.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_prev_ff <= 1'b1;
        end else begin
            rx_prev_ff <= rx_in;
        end
    end

    assign ev.level = rx_in;
    assign ev.rise  = rx_in & ~rx_prev_ff;
    assign ev.fall  = ~rx_in & rx_prev_ff;
endmodule : rx_edge_detect

// >>> rtl/autobaud_rate_detect.sv
// Auto-baud measurement controller: times a sync character on the receive line into the divisor pair.
// Assumes synchronous inputs, software strobes one cycle wide, and a receive line idling high.
`timescale 1ns/1ns

// What this block does
// R1: Measurement may only run while the port is asynchronous and wake-on-receive is clear.
// R2: Setting the arm bit clears the baud counter and then the block waits for a start bit.
// R3: A start bit seen while armed begins the measurement.
// R4: The remote end must send 55h so the alternating bits give the period.
// R5: The count runs across both low and high bit times so asymmetry averages out.
// R6: Counting begins on the first rising edge after the start bit, on the selected counter clock.
// R7: On the fifth rising edge the count stays in the divisor pair and the arm bit clears itself.
// R8: A counter rollover from FFFFh to 0000h sets the overflow flag, which software may also set or clear.
// R9: After a rollover the measurement carries on and the arm bit stays set.
// R10: During measurement the counter ticks at the rate picked by the two rate selects: oscillator over 512, 128 or 32.
// R11: Both divisor bytes form one 16-bit counter whatever the wide-divisor select says.
// R12: While measuring, the port's transfer state machine is held idle.
// R13: The fifth rising edge sets the receive-full flag, and a read of the receive buffer clears it.
// R14: Software reads and discards the receive buffer after completion to clear that flag.
// R15: With wake-on-receive set alongside the arm bit, the break is waited out and the next character is measured once wake-on-receive is cleared.
// R16: Transmit buffer writes are blocked while armed, and arming is refused during a transmission.
// R17: Clearing the arm bit before the fifth edge abandons the measurement and returns to idle.
module autobaud_rate_detect
    import autobaud_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        rx_in,
    input  wire logic        async_mode,
    input  wire logic        wake_on_rx_enable,
    input  wire logic        divisor_wide_select,
    input  wire logic        high_speed_select,
    input  wire logic        arm_set,
    input  wire logic        arm_clear,
    input  wire logic        ovf_set,
    input  wire logic        ovf_clear,
    input  wire logic        divisor_wr_en,
    input  wire logic [15:0] divisor_wr_data,
    input  wire logic        rx_buf_read,
    input  wire logic        tx_write,
    input  wire logic        tx_busy,
    output logic             autobaud_arm,
    output logic             autobaud_measure_mode,
    output logic             autobaud_overflow_flag,
    output logic [7:0]       baud_divisor_low,
    output logic [7:0]       baud_divisor_high,
    output logic             rx_full_flag,
    output logic             port_hold_idle,
    output logic             tx_write_grant
);

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    rx_edge_if ev ();

    rx_edge_detect u_edge (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rx_in   (rx_in),
        .ev      (ev)
    );

    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    abd_state_t  state_ff;
    abd_state_t  nxt_state;
    logic        arm_ff;
    logic        ovf_ff;
    logic        rx_full_ff;
    logic [15:0] div_ff;
    logic [8:0]  pre_ff;
    logic [2:0]  rise_cnt_ff;
    logic        arm_accept;
    logic        done;
    logic        tick;
    logic        counting;
    logic        abort;

    assign arm_accept = arm_set & async_mode & ~tx_busy; // R16
    assign counting   = (state_ff == ST_COUNT);
    // The counter freezes on the closing edge so the result stands exactly as measured.
    assign tick       = counting & ~done & (pre_ff == prescale_last(divisor_wide_select, high_speed_select)); // R10
    assign done       = counting & ev.rise & (rise_cnt_ff == (LAST_RISE - RISE_ONE)); // R7
    assign abort      = ~arm_ff | ~async_mode; // R17

    // ----------------------------------------------------------------
    // Measurement sequence
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (arm_ff && async_mode) begin
                    nxt_state = wake_on_rx_enable ? ST_WAIT_BREAK : ST_WAIT_START; // R15
                end
            end
            ST_WAIT_BREAK: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (ev.rise) begin
                    nxt_state = ST_WAIT_START; // R15
                end
            end
            ST_WAIT_START: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (ev.fall && !wake_on_rx_enable) begin
                    nxt_state = ST_WAIT_RISE; // R3
                end
            end
            ST_WAIT_RISE: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (ev.rise) begin
                    nxt_state = ST_COUNT; // R6
                end
            end
            ST_COUNT: begin
                if (abort || done || wake_on_rx_enable) begin // R9
                    nxt_state = ST_IDLE; // R1
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Rising edges seen since counting began; the first one opens the count.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rise_cnt_ff <= 3'h0;
        end else if (state_ff == ST_WAIT_RISE && ev.rise) begin
            rise_cnt_ff <= FIRST_RISE; // R6
        end else if (counting && ev.rise) begin
            rise_cnt_ff <= rise_cnt_ff + RISE_ONE; // R5
        end
    end

    // ----------------------------------------------------------------
    // Counter clock prescaler and the 16-bit divisor counter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_ff <= 9'h000;
        end else if (!counting || tick) begin
            pre_ff <= 9'h000;
        end else begin
            pre_ff <= pre_ff + PRE_ONE; // R10
        end
    end

    // Software writes are only honoured while no measurement owns the counter.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_ff <= DIV_RESET;
        end else if (arm_accept) begin
            div_ff <= DIV_RESET; // R2
        end else if (tick) begin
            div_ff <= div_ff + DIV_ONE; // R11
        end else if (divisor_wr_en && state_ff == ST_IDLE && !arm_ff) begin
            div_ff <= divisor_wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arm_ff <= 1'b0;
        end else if (arm_accept) begin
            arm_ff <= 1'b1;
        end else if (done || arm_clear) begin
            arm_ff <= 1'b0; // R7 R17
        end
    end

    // A hardware rollover wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ovf_ff <= 1'b0;
        end else if ((tick && div_ff == DIV_MAX) || ovf_set) begin
            ovf_ff <= 1'b1; // R8
        end else if (ovf_clear) begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_full_ff <= 1'b0;
        end else if (done) begin
            rx_full_ff <= 1'b1; // R13
        end else if (rx_buf_read) begin
            rx_full_ff <= 1'b0; // R13 R14
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign autobaud_arm           = arm_ff;
    assign autobaud_measure_mode  = (state_ff != ST_IDLE);
    assign autobaud_overflow_flag = ovf_ff;
    assign baud_divisor_low       = div_ff[7:0];
    assign baud_divisor_high      = div_ff[15:8];
    assign rx_full_flag           = rx_full_ff;
    assign port_hold_idle         = (state_ff != ST_IDLE); // R12
    assign tx_write_grant         = tx_write & ~arm_ff; // R16

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_armed_start;
        state_ff == ST_WAIT_START && ev.fall && !wake_on_rx_enable && arm_ff && async_mode;
    endsequence

    sequence s_fifth_rise;
        counting && ev.rise && rise_cnt_ff == (LAST_RISE - RISE_ONE) && arm_ff && async_mode && !wake_on_rx_enable;
    endsequence

    a_async_only_count: assert property (@(posedge ref_clk) disable iff (rst) // R1
        counting |-> $past(async_mode))
        else $error("counting without asynchronous mode");

    a_arm_clears_div: assert property (@(posedge ref_clk) disable iff (rst) // R2
        arm_accept |=> div_ff == DIV_RESET && arm_ff)
        else $error("arming did not clear the counter");

    a_start_begins: assert property (@(posedge ref_clk) disable iff (rst) // R3
        s_armed_start |=> state_ff == ST_WAIT_RISE)
        else $error("start bit did not begin measurement");

    a_rise_opens_count: assert property (@(posedge ref_clk) disable iff (rst) // R6
        state_ff == ST_WAIT_RISE && ev.rise && arm_ff && async_mode
        |=> counting && rise_cnt_ff == FIRST_RISE)
        else $error("first rise did not open the count");

    a_fifth_rise_ends: assert property (@(posedge ref_clk) disable iff (rst) // R7
        s_fifth_rise and !arm_set |=> !arm_ff && state_ff == ST_IDLE && $stable(div_ff))
        else $error("fifth rise did not finish measurement");

    a_rollover_flag: assert property (@(posedge ref_clk) disable iff (rst) // R8
        tick && div_ff == DIV_MAX |=> ovf_ff && div_ff == DIV_RESET)
        else $error("rollover not flagged");

    a_rollover_keeps: assert property (@(posedge ref_clk) disable iff (rst) // R9
        tick && div_ff == DIV_MAX && !done && !arm_clear && async_mode && !wake_on_rx_enable
        |=> arm_ff && counting)
        else $error("rollover ended measurement");

    a_tick_rate: assert property (@(posedge ref_clk) disable iff (rst) // R10
        tick && divisor_wide_select && high_speed_select
        |=> (!tick) [*8] ##1 (!tick) [*8] ##1 (!tick) [*8] ##1 (!tick) [*7]
            ##1 (tick || done || !counting || !divisor_wide_select || !high_speed_select))
        else $error("counter tick at wrong rate");

    a_hold_idle: assert property (@(posedge ref_clk) disable iff (rst) // R12
        arm_accept ##1 (state_ff == ST_IDLE && arm_ff && async_mode) |=> port_hold_idle && autobaud_measure_mode)
        else $error("port not held idle");

    a_rx_full_set: assert property (@(posedge ref_clk) disable iff (rst) // R13
        done |=> rx_full_flag ##1 (rx_full_flag || $past(rx_buf_read)))
        else $error("receive-full flag not set on completion");

    a_tx_blocked: assert property (@(posedge ref_clk) disable iff (rst) // R16
        arm_accept || (arm_ff && !done && !arm_clear) |=> !tx_write_grant)
        else $error("transmit write passed while armed");

    a_abandon: assert property (@(posedge ref_clk) disable iff (rst) // R17
        arm_clear && !arm_set |=> !arm_ff ##1 state_ff == ST_IDLE)
        else $error("clearing arm did not abandon measurement");

    a_wake_stops_count: assert property (@(posedge ref_clk) disable iff (rst) // R1
        counting && wake_on_rx_enable |=> !counting && !port_hold_idle)
        else $error("counting went on with wake-on-receive set");

    a_rise_accumulates: assert property (@(posedge ref_clk) disable iff (rst) // R5
        counting && ev.rise && !done && arm_ff && async_mode && !wake_on_rx_enable
        |=> counting && rise_cnt_ff == $past(rise_cnt_ff) + RISE_ONE)
        else $error("rising edge not accumulated");

    a_overflow_sw: assert property (@(posedge ref_clk) disable iff (rst) // R8
        ovf_clear && !ovf_set && !(tick && div_ff == DIV_MAX) |=> !autobaud_overflow_flag)
        else $error("software clear of the overflow flag lost");

    a_rx_full_clear: assert property (@(posedge ref_clk) disable iff (rst) // R13
        rx_buf_read && !done |=> !rx_full_flag)
        else $error("receive buffer read did not clear the flag");

    a_break_skipped: assert property (@(posedge ref_clk) disable iff (rst) // R15
        state_ff == ST_WAIT_BREAK && ev.fall && arm_ff && async_mode |=> state_ff == ST_WAIT_BREAK)
        else $error("break started the measurement");

endmodule : autobaud_rate_detect

// >>> bench/sync_tx_model.sv
// Remote transmitter model: sends framed characters or a break on the receive line.
// Assumes each task is called just after a clock edge; the line idles high between frames.
`timescale 1ns/1ns
module sync_tx_model (
    input  wire logic ref_clk,
    output logic      rx_line
);
    initial rx_line = 1'b1;

    task automatic hold_bit(input logic v, input int cyc);
        rx_line = v;
        repeat (cyc) @(posedge ref_clk);
        #1;
    endtask : hold_bit

    // Start bit, eight data bits least significant first, then the stop bit.
    task automatic send_char(input logic [7:0] v, input int cyc);
        hold_bit(1'b0, cyc);
        for (int i = 0; i < 8; i++) begin
            hold_bit(v[i], cyc);
        end
        hold_bit(1'b1, cyc);
    endtask : send_char

    task automatic send_break(input int cyc);
        hold_bit(1'b0, 13 * cyc);
        hold_bit(1'b1, cyc);
    endtask : send_break
endmodule : sync_tx_model

// >>> bench/autobaud_rate_detect_tb_top.sv
// Self-checking bench for the auto-baud measurement block.
// Assumes the remote transmitter model drives the receive line.
`timescale 1ns/1ns
module autobaud_rate_detect_tb_top;
    logic        ref_clk, rst, rx_in, async_mode, wake_on_rx_enable;
    logic        divisor_wide_select, high_speed_select, arm_set, arm_clear;
    logic        ovf_set, ovf_clear, divisor_wr_en, rx_buf_read, tx_write, tx_busy;
    logic [15:0] divisor_wr_data;
    logic        autobaud_arm, autobaud_measure_mode, autobaud_overflow_flag;
    logic [7:0]  baud_divisor_low, baud_divisor_high;
    logic        rx_full_flag, port_hold_idle, tx_write_grant;
    logic [31:0] seed;
    int          mismatches, tests_run;

    autobaud_rate_detect u_dut (.ref_clk(ref_clk), .rst(rst), .rx_in(rx_in), .async_mode(async_mode),
        .wake_on_rx_enable(wake_on_rx_enable), .divisor_wide_select(divisor_wide_select),
        .high_speed_select(high_speed_select), .arm_set(arm_set), .arm_clear(arm_clear),
        .ovf_set(ovf_set), .ovf_clear(ovf_clear), .divisor_wr_en(divisor_wr_en),
        .divisor_wr_data(divisor_wr_data), .rx_buf_read(rx_buf_read), .tx_write(tx_write),
        .tx_busy(tx_busy), .autobaud_arm(autobaud_arm), .autobaud_measure_mode(autobaud_measure_mode),
        .autobaud_overflow_flag(autobaud_overflow_flag), .baud_divisor_low(baud_divisor_low),
        .baud_divisor_high(baud_divisor_high), .rx_full_flag(rx_full_flag),
        .port_hold_idle(port_hold_idle), .tx_write_grant(tx_write_grant));

    sync_tx_model u_tx (.ref_clk(ref_clk), .rx_line(rx_in));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Counter clock divider picked by the two rate selects during measurement.
    function automatic int prescale_of(input logic wide, input logic fast);
        return ({wide, fast} == 2'b00) ? 512 : (({wide, fast} == 2'b11) ? 32 : 128);
    endfunction : prescale_of

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Arms the block and checks the counter clear and the held port.
    task automatic arm_now();
        arm_set = 1'b1;
        tick();
        arm_set = 1'b0;
        tx_write = 1'b1;
        check("arm", 16'(autobaud_arm), 16'h0001);
        check("div_clear", {baud_divisor_high, baud_divisor_low}, 16'h0000);
        tick();
        check("hold_idle", 16'(port_hold_idle), 16'h0001);
        check("tx_grant", 16'(tx_write_grant), 16'h0000);
        tx_write = 1'b0;
    endtask : arm_now

    // Checks the completed measurement against the bit time sent.
    task automatic check_done(input int b, input int p);
        int  exp;
        int  got;
        exp = (8 * b) / p;
        got = int'({baud_divisor_high, baud_divisor_low});
        check("arm_done", 16'(autobaud_arm), 16'h0000);
        check("rx_full", 16'(rx_full_flag), 16'h0001);
        check("mode_done", 16'(autobaud_measure_mode), 16'h0000);
        check("div_range", 16'(got >= exp - 1 && got <= exp + 1), 16'h0001);
        check("hold_done", 16'(port_hold_idle), 16'h0000);
        rx_buf_read = 1'b1;
        tx_write = 1'b1;
        tick();
        rx_buf_read = 1'b0;
        check("rx_full_clr", 16'(rx_full_flag), 16'h0000);
        check("tx_grant_done", 16'(tx_write_grant), 16'h0001);
        tx_write = 1'b0;
    endtask : check_done

    task automatic measure(input logic wide, input logic fast);
        int b;
        divisor_wide_select = wide;
        high_speed_select = fast;
        seed = lfsr_next(seed);
        divisor_wr_data = seed[15:0] | 16'h0100;
        divisor_wr_en = 1'b1;
        tick();
        divisor_wr_en = 1'b0;
        check("div_wr", {baud_divisor_high, baud_divisor_low}, divisor_wr_data);
        b = prescale_of(wide, fast) * (2 + int'(seed[17:16]));
        arm_now();
        u_tx.send_char(8'h55, b);
        check_done(b, prescale_of(wide, fast));
    endtask : measure

    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end

    initial begin
        {rst, async_mode, wake_on_rx_enable, divisor_wide_select, high_speed_select} = 5'b11000;
        {arm_set, arm_clear, ovf_set, ovf_clear, divisor_wr_en, rx_buf_read, tx_write, tx_busy} = 8'h00;
        divisor_wr_data = 16'h0000;
        seed = 32'h2938;
        mismatches = 0;
        tests_run = 0;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check("ovf_rst", 16'(autobaud_overflow_flag), 16'h0000);
        check("div_rst", {baud_divisor_high, baud_divisor_low}, 16'h0000);
        async_mode = 1'b0;
        arm_set = 1'b1;
        tick();
        arm_set = 1'b0;
        check("arm_sync", 16'(autobaud_arm), 16'h0000);
        {async_mode, tx_busy, arm_set} = 3'b111;
        tick();
        {tx_busy, arm_set, ovf_set} = 3'b001;
        check("arm_busy", 16'(autobaud_arm), 16'h0000);
        tick();
        {ovf_set, ovf_clear} = 2'b01;
        check("ovf_set", 16'(autobaud_overflow_flag), 16'h0001);
        tick();
        ovf_clear = 1'b0;
        check("ovf_clr", 16'(autobaud_overflow_flag), 16'h0000);
        for (int m = 0; m < 4; m++) begin
            measure(m[1], m[0]);
        end
        // Abandon a measurement part way through the character.
        arm_now();
        fork
            u_tx.send_char(8'h55, 64);
            begin
                repeat (256) tick();
                arm_clear = 1'b1;
                tick();
                arm_clear = 1'b0;
                check("arm_abort", 16'(autobaud_arm), 16'h0000);
                tick();
                check("mode_abort", 16'(autobaud_measure_mode), 16'h0000);
            end
        join
        check("rx_full_abort", 16'(rx_full_flag), 16'h0000);
        // Armed with wake-on-receive: the break is skipped, the next character is timed.
        wake_on_rx_enable = 1'b1;
        arm_now();
        u_tx.send_break(96);
        wake_on_rx_enable = 1'b0;
        u_tx.send_char(8'h55, 96);
        check_done(96, 32);
        summarize();
    end
endmodule : autobaud_rate_detect_tb_top
